// ===== src/io_port_top.sv
// input-only port, seven-pin I/O port and their AXI4-Lite registers
// How it works
// - eight input pins, no drivers, no direction
// - input pin register reads live pin states
// - writing its address sets other port direction
// - low six input pins feed analog inputs
// - direction bits 6..0: 1 output, write-only
// - direction address reads other port pins
// - output latch bits 6..0 read/write, reset 0
// - read: latch if output, pin if input
// - effective two-wire enable gated by alternate selects
// - top pin: GPIO, serial clock out or in
// - two-wire clock whenever effective enable set
// - interrupt 5 input fed when enabled
// - push-pull except open-drain two-wire clock
module io_port_top (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic [4:0]  AWADDR,
    input  wire logic        AWVALID,
    output wire logic        AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output wire logic        WREADY,
    output wire logic [1:0]  BRESP,
    output wire logic        BVALID,
    input  wire logic        BREADY,
    input  wire logic [4:0]  ARADDR,
    input  wire logic        ARVALID,
    output wire logic        ARREADY,
    output wire logic [31:0] RDATA,
    output wire logic [1:0]  RRESP,
    output wire logic        RVALID,
    input  wire logic        RREADY,
    input  wire logic [7:0]  INPUT_PIN,
    output wire logic [5:0]  ANALOG_INPUT,
    input  wire logic [7:0]  OTHER_PORT_PIN_STATE,
    output wire logic [7:0]  OTHER_PORT_DIRECTION,
    input  wire logic [6:0]  IO_PIN_IN,
    output wire logic [6:0]  IO_PIN_OUT,
    output wire logic [6:0]  IO_PIN_OE,
    input  wire logic        SERIAL_CLOCK_OUT,
    output wire logic        SERIAL_CLOCK_IN,
    input  wire logic        TWOWIRE_CLOCK_LOW,
    output wire logic        TWOWIRE_CLOCK_IN,
    output wire logic        INTERRUPT_INPUT_5
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  in_a;
        logic [7:0]  in_b;
        logic [7:0]  oth_a;
        logic [7:0]  oth_b;
        logic [6:0]  io_a;
        logic [6:0]  io_b;
        logic [7:0]  other_dir;
        logic [7:0]  io_direction;
        logic [7:0]  io_output_latch;
        logic [7:0]  ctrl;
        logic        aw_got;
        logic [4:0]  awaddr;
        logic        w_got;
        logic [7:0]  wdata;
        logic        wlane;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [5:0]  analog;
        logic [5:0]  io_out;
        logic [5:0]  io_oe;
    } state_t;

    localparam state_t RST_STATE = '{
        other_dir:       port_pkg::OTHER_DIR_RST,
        io_direction:    port_pkg::IO_DIR_RST,
        io_output_latch: port_pkg::IO_LATCH_RST,
        ctrl:            port_pkg::CTRL_RST,
        awready:         1'b1,
        wready:          1'b1,
        arready:         1'b1,
        default:         '0
    };

    state_t     s;
    state_t     next_s;
    logic [7:0] stat;

    top_pin_if m ();

    top_pin_mux u_mux (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .m     (m.mux)
    );

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic readable(logic [4:0] a);
        return a[4:2] <= port_pkg::OFS_MUX_STAT[4:2];
    endfunction

    function automatic logic [31:0] read_word(state_t st, logic [4:0] a, logic [7:0] sv);
        logic [7:0] v;
        v = 8'h00;
        case (a[4:2])
            port_pkg::OFS_INPUT_STATE[4:2]: v = st.in_b;
            port_pkg::OFS_IO_DIR[4:2]:      v = st.oth_b;
            port_pkg::OFS_IO_LATCH[4:2]:
                v = {1'b1, (st.io_output_latch[6:0] & st.io_direction[6:0])
                         | (st.io_b & ~st.io_direction[6:0])};
            port_pkg::OFS_MUX_CTRL[4:2]:    v = st.ctrl;
            port_pkg::OFS_MUX_STAT[4:2]:    v = sv;
            default:                        v = 8'h00;
        endcase
        return {24'h000000, v};
    endfunction

    assign stat = {4'h0, m.fn, m.eff_twe};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        // pin synchronisers: input port pins carry no driver at all
        next_s.in_a   = INPUT_PIN;
        next_s.in_b   = s.in_a;
        next_s.oth_a  = OTHER_PORT_PIN_STATE;
        next_s.oth_b  = s.oth_a;
        next_s.io_a   = IO_PIN_IN;
        next_s.io_b   = s.io_a;
        next_s.analog = s.in_b[5:0];
        next_s.io_out = s.io_output_latch[5:0];
        next_s.io_oe  = s.io_direction[5:0];

        if (AWVALID && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = AWADDR;
        end
        if (WVALID && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = WDATA[7:0];
            next_s.wlane = WSTRB[0];
        end

        if (s.aw_got && s.w_got) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = port_pkg::RESP_OKAY;
            case (s.awaddr[4:2])
                port_pkg::OFS_INPUT_STATE[4:2]:
                    if (s.wlane) begin
                        next_s.other_dir = s.wdata;
                    end
                port_pkg::OFS_IO_DIR[4:2]:
                    if (s.wlane) begin
                        // reserved top bit stays at 1
                        next_s.io_direction = {1'b1, s.wdata[6:0]};
                    end
                port_pkg::OFS_IO_LATCH[4:2]:
                    if (s.wlane) begin
                        next_s.io_output_latch = {1'b1, s.wdata[6:0]};
                    end
                port_pkg::OFS_MUX_CTRL[4:2]:
                    if (s.wlane) begin
                        next_s.ctrl = s.wdata;
                    end
                default: next_s.bresp = port_pkg::RESP_SLVERR;
            endcase
        end else if (s.bvalid && BREADY) begin
            next_s.bvalid = 1'b0;
        end
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready  = !next_s.w_got && !next_s.bvalid;

        if (ARVALID && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = read_word(s, ARADDR, stat);
            next_s.rresp  = readable(ARADDR) ? port_pkg::RESP_OKAY : port_pkg::RESP_SLVERR;
        end else if (s.rvalid && RREADY) begin
            next_s.rvalid = 1'b0;
        end
        next_s.arready = !next_s.rvalid;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // top pin connection
    // ------------------------------------------------------------
    assign m.sps     = s.ctrl[port_pkg::CTL_SPS];
    assign m.serial_clock_enable_0    = s.ctrl[port_pkg::CTL_SERIAL_CLOCK_ENABLE_0];
    assign m.serial_clock_enable_1    = s.ctrl[port_pkg::CTL_SERIAL_CLOCK_ENABLE_1];
    assign m.cm      = s.ctrl[port_pkg::CTL_CM];
    assign m.twe     = s.ctrl[port_pkg::CTL_TWE];
    assign m.alta    = s.ctrl[port_pkg::CTL_ALTA];
    assign m.altb    = s.ctrl[port_pkg::CTL_ALTB];
    assign m.interrupt5_enable   = s.ctrl[port_pkg::CTL_INTERRUPT5_ENABLE];
    assign m.dir     = s.io_direction[6];
    assign m.latch   = s.io_output_latch[6];
    assign m.pin     = s.io_b[6];
    assign m.sck_out = SERIAL_CLOCK_OUT;
    assign m.scl_low = TWOWIRE_CLOCK_LOW;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign AWREADY              = s.awready;
    assign WREADY               = s.wready;
    assign BVALID               = s.bvalid;
    assign BRESP                = s.bresp;
    assign ARREADY              = s.arready;
    assign RVALID               = s.rvalid;
    assign RRESP                = s.rresp;
    assign RDATA                = s.rdata;
    assign ANALOG_INPUT         = s.analog;
    assign OTHER_PORT_DIRECTION = s.other_dir;
    assign IO_PIN_OUT           = {m.pin_out, s.io_out};
    assign IO_PIN_OE            = {m.pin_oe, s.io_oe};
    assign SERIAL_CLOCK_IN      = m.sck_in;
    assign TWOWIRE_CLOCK_IN     = m.scl_in;
    assign INTERRUPT_INPUT_5    = m.interrupt_input_5;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sequence wr_commit(logic [2:0] idx);
        s.aw_got && s.w_got && s.wlane && s.awaddr[4:2] == idx;
    endsequence

    sequence rd_take(logic [2:0] idx);
        ARVALID && ARREADY && ARADDR[4:2] == idx;
    endsequence

    chk_input_live: assert property (
        rd_take(port_pkg::OFS_INPUT_STATE[4:2]) |=> RVALID && RDATA[7:0] == $past(s.in_b))
        else $error("input pin read not live");
    chk_other_dir_write: assert property (
        wr_commit(port_pkg::OFS_INPUT_STATE[4:2])
            |=> BVALID && OTHER_PORT_DIRECTION == $past(s.wdata))
        else $error("shared address write missed other port direction");
    // two synchroniser flops, then the registered copy
    chk_analog_follow: assert property (
        $past(RST_N, 3) && $past(RST_N, 2) && $past(RST_N)
            |-> ANALOG_INPUT == $past(INPUT_PIN[5:0], 3))
        else $error("analog inputs do not follow low pins");
    chk_io_dir_drive: assert property (
        wr_commit(port_pkg::OFS_IO_DIR[4:2])
            |=> ##1 IO_PIN_OE[5:0] == $past(s.wdata[5:0], 2))
        else $error("direction write did not reach enables");
    chk_shared_read: assert property (
        rd_take(port_pkg::OFS_IO_DIR[4:2]) |=> RDATA[7:0] == $past(s.oth_b))
        else $error("direction address did not read other port pins");
    chk_latch_write: assert property (
        wr_commit(port_pkg::OFS_IO_LATCH[4:2])
            |=> ##1 IO_PIN_OUT[5:0] == $past(s.wdata[5:0], 2))
        else $error("latch write did not reach pins");
    chk_latch_read: assert property (
        rd_take(port_pkg::OFS_IO_LATCH[4:2]) |=> RDATA[7:0] == {1'b1,
            ($past(s.io_output_latch[6:0]) & $past(s.io_direction[6:0]))
            | ($past(s.io_b) & ~$past(s.io_direction[6:0]))})
        else $error("latch read mixes pins wrongly");
    chk_gpio_drive: assert property (
        $stable(s.io_output_latch) [*2] |-> IO_PIN_OUT[5:0] == s.io_output_latch[5:0])
        else $error("general output not driving latch");

    // ------------------------------------------------------------
    // side effects
    // ------------------------------------------------------------
    chk_oe_follow_dir: assert property (
        $past(RST_N) |-> IO_PIN_OE[5:0] == $past(s.io_direction[5:0]))
        else $error("pin enables do not follow direction bits");
    chk_latch_no_lane: assert property (
        (s.aw_got && s.w_got && !s.wlane) |=> $stable(s.io_output_latch))
        else $error("write without lane 0 changed the output latch");
    chk_other_dir_only: assert property (
        (s.aw_got && s.w_got && s.awaddr[4:2] != port_pkg::OFS_INPUT_STATE[4:2])
            |=> $stable(OTHER_PORT_DIRECTION))
        else $error("other port direction changed by another address");
    chk_irq_enable_gate: assert property (
        INTERRUPT_INPUT_5 |-> $past(s.ctrl[port_pkg::CTL_INTERRUPT5_ENABLE]))
        else $error("interrupt 5 raised while not enabled");

endmodule

// ===== src/port_pkg.sv
// shared constants and types for the input port and the I/O port
package port_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_INPUT_STATE = 5'h00;
    localparam logic [4:0] OFS_IO_DIR      = 5'h04;
    localparam logic [4:0] OFS_IO_LATCH    = 5'h08;
    localparam logic [4:0] OFS_MUX_CTRL    = 5'h0c;
    localparam logic [4:0] OFS_MUX_STAT    = 5'h10;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTL_SPS   = 0;
    localparam int CTL_SERIAL_CLOCK_ENABLE_0  = 1;
    localparam int CTL_SERIAL_CLOCK_ENABLE_1  = 2;
    localparam int CTL_CM    = 3;
    localparam int CTL_TWE   = 4;
    localparam int CTL_ALTA  = 5;
    localparam int CTL_ALTB  = 6;
    localparam int CTL_INTERRUPT5_ENABLE = 7;

    // ------------------------------------------------------------
    // status fields, reset values, responses
    // ------------------------------------------------------------
    localparam int STAT_EFF    = 0;
    localparam int STAT_FN_LSB = 1;
    localparam logic [7:0] IO_DIR_RST    = 8'h80;
    localparam logic [7:0] IO_LATCH_RST  = 8'h80;
    localparam logic [7:0] OTHER_DIR_RST = 8'h00;
    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    typedef enum logic [2:0] {
        FN_GPIO_IN  = 3'h0,
        FN_GPIO_OUT = 3'h1,
        FN_SCK_OUT  = 3'h2,
        FN_SCK_IN   = 3'h3,
        FN_SCL      = 3'h4
    } pin_fn_t;

endpackage

// ===== src/top_pin_if.sv
// signals between the register block and the top-pin multiplexer
interface top_pin_if;
    logic              sps;
    logic              serial_clock_enable_0;
    logic              serial_clock_enable_1;
    logic              cm;
    logic              twe;
    logic              alta;
    logic              altb;
    logic              interrupt5_enable;
    logic              dir;
    logic              latch;
    logic              pin;
    logic              sck_out;
    logic              scl_low;
    logic              pin_out;
    logic              pin_oe;
    logic              sck_in;
    logic              scl_in;
    logic              interrupt_input_5;
    logic              eff_twe;
    port_pkg::pin_fn_t fn;

    modport ctrl (output sps, serial_clock_enable_0, serial_clock_enable_1, cm, twe, alta, altb, interrupt5_enable, dir, latch, pin,
                  output sck_out, scl_low,
                  input  pin_out, pin_oe, sck_in, scl_in, interrupt_input_5, eff_twe, fn);
    modport mux  (input  sps, serial_clock_enable_0, serial_clock_enable_1, cm, twe, alta, altb, interrupt5_enable, dir, latch, pin,
                  input  sck_out, scl_low,
                  output pin_out, pin_oe, sck_in, scl_in, interrupt_input_5, eff_twe, fn);
endinterface

// ===== src/top_pin_mux.sv
// function select for the top pin of the I/O port
module top_pin_mux (
    input wire logic clk,
    input wire logic rst_n,
    top_pin_if.mux   m
);

    typedef struct packed {
        logic              pin_out;
        logic              pin_oe;
        logic              sck_in;
        logic              scl_in;
        logic              interrupt_input_5;
        logic              eff;
        port_pkg::pin_fn_t fn;
    } mux_t;

    localparam mux_t MUX_RST = '{scl_in: 1'b1, fn: port_pkg::FN_GPIO_IN, default: 1'b0};

    mux_t s;
    mux_t next_s;

    // ------------------------------------------------------------
    // pin function
    // ------------------------------------------------------------
    always_comb begin
        next_s         = s;
        next_s.eff     = m.twe & ~(m.alta | m.altb);
        next_s.interrupt_input_5    = m.interrupt5_enable & m.pin;
        next_s.sck_in  = 1'b0;
        next_s.scl_in  = 1'b1;
        next_s.pin_out = m.latch;
        next_s.pin_oe  = m.dir;
        next_s.fn      = m.dir ? port_pkg::FN_GPIO_OUT : port_pkg::FN_GPIO_IN;
        if (next_s.eff) begin
            // open drain: only ever pulls low
            next_s.fn      = port_pkg::FN_SCL;
            next_s.pin_out = 1'b0;
            next_s.pin_oe  = m.scl_low;
            next_s.scl_in  = m.pin;
        end else if (!m.sps && m.serial_clock_enable_1) begin
            next_s.fn      = port_pkg::FN_SCK_IN;
            next_s.pin_out = 1'b0;
            next_s.pin_oe  = 1'b0;
            next_s.sck_in  = m.pin;
        end else if (!m.sps && (m.serial_clock_enable_0 || m.cm)) begin
            next_s.fn      = port_pkg::FN_SCK_OUT;
            next_s.pin_out = m.sck_out;
            next_s.pin_oe  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= MUX_RST;
        end else begin
            s <= next_s;
        end
    end

    assign m.pin_out = s.pin_out;
    assign m.pin_oe  = s.pin_oe;
    assign m.sck_in  = s.sck_in;
    assign m.scl_in  = s.scl_in;
    assign m.interrupt_input_5    = s.interrupt_input_5;
    assign m.eff_twe = s.eff;
    assign m.fn      = s.fn;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_twowire_gate: assert property (
        (m.twe && (m.alta || m.altb)) |=> (m.fn != port_pkg::FN_SCL && !m.eff_twe))
        else $error("alternate select did not block the two-wire clock");
    chk_scl_low_only: assert property (
        (m.twe && !m.alta && !m.altb) |=> (m.fn == port_pkg::FN_SCL && !m.pin_out
                                          && m.pin_oe == $past(m.scl_low)))
        else $error("two-wire clock pin not open drain");
    chk_irq_follow: assert property (
        m.interrupt5_enable |=> m.interrupt_input_5 == $past(m.pin))
        else $error("interrupt 5 does not follow the pin");
    chk_sck_drive: assert property (
        (!m.sps && !m.twe && !m.serial_clock_enable_1 && (m.serial_clock_enable_0 || m.cm))
            |=> (m.pin_oe && m.pin_out == $past(m.sck_out)))
        else $error("serial clock not driven on the pin");
    chk_gpio_select: assert property (
        (m.sps && !m.twe) |=> (m.pin_oe == $past(m.dir) && m.pin_out == $past(m.latch)))
        else $error("pin not general I/O with select set");

endmodule

// ===== verification/pin_board_model.sv
// board pins and serial peripherals on the far side of the I/O port
module pin_board_model (
    input  wire logic       clk,
    input  wire logic [6:0] pin_out,
    input  wire logic [6:0] pin_oe,
    input  wire logic [6:0] board_level,
    input  wire logic       sclk_level,
    input  wire logic       tw_pull,
    output logic      [6:0] pin_in,
    output logic            sclk,
    output logic            tw_low
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // pin levels
    // ------------------------------------------------------------
    // device driver wins, else board level; pin 6 pull-up via board_level
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : board_level[i];
        end
    end

    // ------------------------------------------------------------
    // serial and two-wire units
    // ------------------------------------------------------------
    initial sclk = 1'b0;
    initial tw_low = 1'b0;
    always @(posedge clk) begin
        sclk   <= sclk_level;
        tw_low <= tw_pull;
    end
endmodule

// ===== verification/io_port_top_bench.sv
// self-checking bench for the input port and the I/O port
module io_port_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  awaddr = '0;
    logic [4:0]  araddr = '0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = '0;
    logic [7:0]  in_pin = '0;
    logic [7:0]  oth_pin = 8'h5a;
    logic [6:0]  board = '0;
    logic        sclk_lvl = 1'b0;
    logic        tw_pull = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [5:0]  analog;
    logic [7:0]  oth_dir;
    logic [6:0]  pin_in, pin_out, pin_oe;
    logic        sclk, sclk_in, tw_low, tw_in, int5;
    logic [1:0]  r;
    logic [31:0] d;
    int          err_count = 0;
    int          checks = 0;

    typedef struct packed {
        logic [7:0] ctrl;
        logic       dir6;
        logic [2:0] fn;
        logic       oe6;
    } mux_row_t;
    mux_row_t rows [11] = '{
        '{8'h00, 1'b0, 3'h0, 1'b0}, '{8'h00, 1'b1, 3'h1, 1'b1},
        '{8'h02, 1'b0, 3'h2, 1'b1}, '{8'h08, 1'b0, 3'h2, 1'b1},
        '{8'h04, 1'b1, 3'h3, 1'b0}, '{8'h10, 1'b1, 3'h4, 1'b0},
        '{8'h30, 1'b0, 3'h0, 1'b0}, '{8'h50, 1'b1, 3'h1, 1'b1},
        '{8'h11, 1'b0, 3'h4, 1'b0}, '{8'h03, 1'b0, 3'h0, 1'b0},
        '{8'h05, 1'b1, 3'h1, 1'b1}};

    always #25 clk_sys = ~clk_sys;

    io_port_top io_port_top_i (
        .CLK_SYS(clk_sys), .RST_N(rst_n),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .INPUT_PIN(in_pin), .ANALOG_INPUT(analog),
        .OTHER_PORT_PIN_STATE(oth_pin), .OTHER_PORT_DIRECTION(oth_dir),
        .IO_PIN_IN(pin_in), .IO_PIN_OUT(pin_out), .IO_PIN_OE(pin_oe),
        .SERIAL_CLOCK_OUT(sclk), .SERIAL_CLOCK_IN(sclk_in),
        .TWOWIRE_CLOCK_LOW(tw_low), .TWOWIRE_CLOCK_IN(tw_in),
        .INTERRUPT_INPUT_5(int5)
    );

    pin_board_model pin_board_model_i (
        .clk(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
        .board_level(board), .sclk_level(sclk_lvl), .tw_pull(tw_pull),
        .pin_in(pin_in), .sclk(sclk), .tw_low(tw_low)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] v, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_sys);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, v};
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 50);
        r = bresp;
        bready <= 1'b0;
        if (n >= 50) err_count++;
    endtask

    task automatic rd(input logic [4:0] a);
        int n;
        n = 0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 50) err_count++;
    endtask

    task automatic wr_ok(input logic [4:0] a, input logic [7:0] v);
        wr(a, v, 4'hf);
        check("write resp", r, port_pkg::RESP_OKAY);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string what);
        rd(a);
        check(what, d, {24'h0, exp});
        check("read resp", r, port_pkg::RESP_OKAY);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        tick(6000);
        $display("watchdog expired");
        err_count++;
        summarize();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        tick(16);
        rst_n <= 1'b1;
        foreach (rows[k]) begin
            wr_ok(port_pkg::OFS_IO_DIR, {1'b1, rows[k].dir6, 6'h00});
            wr_ok(port_pkg::OFS_MUX_CTRL, rows[k].ctrl);
            tick(3);
            rd_chk(port_pkg::OFS_MUX_STAT, {4'h0, rows[k].fn, rows[k].fn == 3'h4}, "status");
            check("pin6 oe", pin_oe[6], rows[k].oe6);
        end
        $display("test pin6 table done");
        wr_ok(port_pkg::OFS_MUX_CTRL, 8'h00);
        for (int k = 0; k < 2; k++) begin
            in_pin <= k ? 8'h3a : 8'hc5;
            tick(5);
            rd_chk(port_pkg::OFS_INPUT_STATE, in_pin, "input pins");
            check("analog", analog, in_pin[5:0]);
        end
        wr_ok(port_pkg::OFS_INPUT_STATE, 8'h3c);
        tick(2);
        check("other dir", oth_dir, 8'h3c);
        rd_chk(port_pkg::OFS_INPUT_STATE, in_pin, "input pins again");
        rd_chk(port_pkg::OFS_IO_DIR, oth_pin, "other pins");
        $display("test shared addresses done");
        board <= 7'h2a;
        wr_ok(port_pkg::OFS_IO_DIR, 8'h8f);
        wr_ok(port_pkg::OFS_IO_LATCH, 8'hd5);
        tick(3);
        check("pin oe", pin_oe, 7'h0f);
        check("pin out", pin_out[3:0], 4'h5);
        rd_chk(port_pkg::OFS_IO_LATCH, 8'ha5, "latch mixed");
        wr_ok(port_pkg::OFS_IO_DIR, 8'h80);
        tick(3);
        check("pin oe off", pin_oe, 7'h00);
        rd_chk(port_pkg::OFS_IO_LATCH, 8'haa, "latch inputs");
        wr(port_pkg::OFS_IO_LATCH, 8'h80, 4'h0);
        check("no lane resp", r, port_pkg::RESP_OKAY);
        wr_ok(port_pkg::OFS_IO_DIR, 8'h8f);
        tick(3);
        check("latch kept", pin_out[3:0], 4'h5);
        $display("test data path done");
        board <= 7'h40;
        wr_ok(port_pkg::OFS_MUX_CTRL, 8'h80);
        tick(4);
        check("irq gpio", int5, 1'b1);
        wr_ok(port_pkg::OFS_MUX_CTRL, 8'h90);
        tick(4);
        check("irq twowire", int5, 1'b1);
        check("tw in high", tw_in, 1'b1);
        tw_pull <= 1'b1;
        tick(6);
        check("tw oe", pin_oe[6], 1'b1);
        check("tw low", pin_out[6], 1'b0);
        check("tw in low", tw_in, 1'b0);
        check("irq low", int5, 1'b0);
        tw_pull <= 1'b0;
        wr_ok(port_pkg::OFS_MUX_CTRL, 8'h02);
        sclk_lvl <= 1'b1;
        tick(4);
        check("sck high", pin_out[6], 1'b1);
        sclk_lvl <= 1'b0;
        tick(4);
        check("sck low", pin_out[6], 1'b0);
        wr_ok(port_pkg::OFS_MUX_CTRL, 8'h04);
        tick(4);
        check("sck in", sclk_in, 1'b1);
        $display("test pin6 functions done");
        wr(port_pkg::OFS_MUX_STAT, 8'hff, 4'hf);
        check("ro write", r, port_pkg::RESP_SLVERR);
        rd(5'h14);
        check("unmapped resp", r, port_pkg::RESP_SLVERR);
        check("unmapped data", d, 32'h0);
        board <= 7'h00;
        rst_n <= 1'b0;
        tick(16);
        rst_n <= 1'b1;
        tick(4);
        check("rst other dir", oth_dir, 8'h00);
        check("rst oe", pin_oe, 7'h00);
        check("rst tw in", tw_in, 1'b1);
        check("rst irq", int5, 1'b0);
        check("rst sck in", sclk_in, 1'b0);
        check("rst pin out", pin_out, 7'h00);
        rd_chk(port_pkg::OFS_IO_LATCH, 8'h80, "rst latch");
        rd_chk(port_pkg::OFS_MUX_CTRL, 8'h00, "rst ctrl");
        $display("test reset and refusals done");
        summarize();
    end
endmodule
